// File: rtl/reader_power_mode_sequencer.sv
// Purpose: power-state sequencer for a 13.56 MHz reader front end
// Assumes: pins and analog ready flags are asynchronous; APB master on clk
// Notes: status control at 0x00, read-only status at 0x04; zero-wait slave
`timescale 1ns/1ps
`default_nettype none
module reader_power_mode_sequencer #(
    parameter int WAKE_CYCLES = power_seq_pkg::WAKE_WINDOW_CYCLES,
    parameter int STBY_CYCLES = power_seq_pkg::STANDBY_RECOVER_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    // enable pins and analog ready flags
    input wire logic mainEnablePin,
    input wire logic wakeEnablePin,
    input wire logic regulatorsSettled,
    input wire logic oscillatorStable,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power and clock controls
    output logic regulatorEnable,
    output logic oscillatorEnable,
    output logic hostRailEnable,
    output logic hostClockAuxOn,
    output logic hostClockHfOn,
    output logic transmitterEnable,
    output logic receiverEnable,
    output logic halfPower,
    output logic supplyFiveVolt,
    output logic rxInputSwap
);
    localparam logic [power_seq_pkg::CNT_W-1:0] WAKE_LAST =
        power_seq_pkg::CNT_W'(WAKE_CYCLES - 1);
    localparam logic [power_seq_pkg::CNT_W-1:0] STBY_LOAD =
        power_seq_pkg::CNT_W'(STBY_CYCLES);
    localparam logic [power_seq_pkg::CNT_W-1:0] M1_LOAD =
        power_seq_pkg::CNT_W'(power_seq_pkg::MODE1_RECOVER_CYCLES);

    // two-stage synchronisers for pins and analog flags
    logic [3:0] syncA; // first stage, read by syncB only
    logic [3:0] syncB; // settled copies
    logic wakePrev; // last settled wake level
    wire mainEn = syncB[0];
    wire wakeEn = syncB[1];
    wire regOk = syncB[2];
    wire oscOk = syncB[3];
    wire wakeRise = wakeEn & ~wakePrev;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syncA <= 4'h0;
            syncB <= 4'h0;
            wakePrev <= 1'b0;
        end else begin
            syncA <= {oscillatorStable, regulatorsSettled, wakeEnablePin, mainEnablePin};
            syncB <= syncA;
            wakePrev <= syncB[1];
        end
    end

    // sequencer state and counters
    power_seq_pkg::seq_state_t state; // current power state
    power_seq_pkg::seq_state_t next_state;
    logic fromWake; // start-up was launched by the wake pin
    logic [power_seq_pkg::CNT_W-1:0] wakeCnt; // cycles spent in WakeWait since fast clock came up
    logic [power_seq_pkg::CNT_W-1:0] recoverCnt; // radio recovery countdown
    logic [7:0] csc; // status control register

    wire settled = regOk & oscOk;
    wire wakeExpired = (wakeCnt == WAKE_LAST);
    wire idleTarget = wakeEn; // where a dropped enable lands

    // next-state decode
    always_comb begin
        next_state = state;
        unique case (state)
            power_seq_pkg::PowerDown: begin
                // either pin starts the supplies
                if (mainEn || wakeRise) begin
                    next_state = power_seq_pkg::Startup; // R1 R3
                end
            end
            power_seq_pkg::Sleep: begin
                if (mainEn) begin
                    next_state = power_seq_pkg::Startup; // R1
                end else if (!wakeEn) begin
                    next_state = power_seq_pkg::PowerDown;
                end
            end
            power_seq_pkg::Startup: begin
                // enable-launched start aborts if enable drops
                if (!fromWake && !mainEn) begin
                    next_state = idleTarget ? power_seq_pkg::Sleep : power_seq_pkg::PowerDown;
                end else if (settled) begin
                    // fast clock only once supplies and crystal are good
                    next_state = mainEn ? power_seq_pkg::Active : power_seq_pkg::WakeWait; // R6
                end
            end
            power_seq_pkg::WakeWait: begin
                if (mainEn) begin
                    next_state = power_seq_pkg::Active; // R5
                end else if (wakeExpired) begin
                    next_state = power_seq_pkg::PowerDown; // R4
                end
            end
            power_seq_pkg::Active: begin
                // stays up exactly as long as enable is held
                if (!mainEn) begin
                    next_state = idleTarget ? power_seq_pkg::Sleep
                        : power_seq_pkg::PowerDown; // R5
                end
            end
        endcase
    end

    // state register and wake-window counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= power_seq_pkg::PowerDown;
            fromWake <= 1'b0;
            wakeCnt <= '0;
        end else begin
            state <= next_state;
            if (state != power_seq_pkg::Startup && next_state == power_seq_pkg::Startup) begin
                fromWake <= ~mainEn; // R3
            end
            // counts only while waiting for the host after a wake start
            wakeCnt <= (state == power_seq_pkg::WakeWait) ? wakeCnt + 1'b1 : '0; // R4
        end
    end

    // active-mode decode of the status control bits
    wire isActive = (state == power_seq_pkg::Active);
    wire standby = csc[power_seq_pkg::CSC_STANDBY_BIT]; // R10
    wire rfOn = csc[power_seq_pkg::CSC_RFON_BIT]; // R13
    wire rxOnly = csc[power_seq_pkg::CSC_RXONLY_BIT]; // R12
    wire wantRx = isActive & ~standby & (rfOn | rxOnly); // R9 R11
    wire wantTx = isActive & ~standby & rfOn; // R12 R13
    wire recovering = (recoverCnt != '0);
    wire hfUp = isActive | (state == power_seq_pkg::WakeWait);
    wire auxUp = (state == power_seq_pkg::Sleep) | (state == power_seq_pkg::Startup);

    // radio recovery: standby and mode 1 each have their own wake delay
    logic wasStandby; // radio was parked in standby
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            recoverCnt <= '0;
            wasStandby <= 1'b0;
        end else begin
            wasStandby <= isActive & standby;
            if (!isActive) begin
                recoverCnt <= '0;
            end else if (standby) begin
                recoverCnt <= STBY_LOAD; // R10
            end else if (!(rfOn | rxOnly)) begin
                // mode 1 keeps bias warm, so the shorter delay applies
                recoverCnt <= wasStandby ? STBY_LOAD : M1_LOAD; // R11
            end else if (recovering) begin
                recoverCnt <= recoverCnt - 1'b1;
            end
        end
    end

    // output flops: every pin control comes straight from a register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regulatorEnable <= 1'b0;
            oscillatorEnable <= 1'b0;
            hostRailEnable <= 1'b0;
            hostClockAuxOn <= 1'b0;
            hostClockHfOn <= 1'b0;
            transmitterEnable <= 1'b0;
            receiverEnable <= 1'b0;
            halfPower <= 1'b0;
            supplyFiveVolt <= 1'b1;
            rxInputSwap <= 1'b0;
        end else begin
            regulatorEnable <= hfUp | (state == power_seq_pkg::Startup); // R1
            oscillatorEnable <= hfUp | (state == power_seq_pkg::Startup); // R1
            hostRailEnable <= (state != power_seq_pkg::PowerDown); // R2
            hostClockAuxOn <= auxUp; // R2 R6
            hostClockHfOn <= hfUp; // R1 R6 R14
            transmitterEnable <= wantTx & ~recovering; // R13
            receiverEnable <= wantRx & ~recovering; // R12
            halfPower <= wantTx & csc[power_seq_pkg::CSC_HALF_BIT]; // R16
            supplyFiveVolt <= csc[power_seq_pkg::CSC_SUPPLY5_BIT]; // R15
            rxInputSwap <= csc[power_seq_pkg::CSC_RXSWAP_BIT];
        end
    end

    // apb decode: answer is registered, so access phase lasts one cycle
    wire setup = psel & ~penable;
    wire access = psel & penable & pready;
    wire hitCsc = (paddr == power_seq_pkg::CSC_ADDR);
    wire hitStatus = (paddr == power_seq_pkg::STATUS_ADDR);
    wire mapped = hitCsc | hitStatus;
    wire wrCsc = access & pwrite & hitCsc & ~pslverr;
    wire [31:0] statusWord = {21'h00000, recovering, transmitterEnable, receiverEnable,
        hostClockHfOn, hostClockAuxOn, hostRailEnable, fromWake, 1'b0, state};
    wire [31:0] readWord = hitCsc ? {24'h000000, csc} : (hitStatus ? statusWord : 32'h00000000);

    // bus answer and register write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            csc <= power_seq_pkg::CSC_RESET;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= (setup & ~pwrite) ? readWord : 32'h00000000;
            // host programs the mode once the fast clock is up
            if (wrCsc) begin
                csc <= pwdata[7:0]; // R9 R14
            end
        end
    end

    // assertions
    sequence s_fastClockUp;
        state == power_seq_pkg::Startup && settled && mainEn;
    endsequence

    property p_enable_powers;
        @(posedge clk) disable iff (!rst_b)
        (state == power_seq_pkg::PowerDown && mainEn) |=> ##1 regulatorEnable && oscillatorEnable;
    endproperty
    a_enable_powers: assert property (p_enable_powers) // R1
        else $error("enable did not power up");

    property p_sleep_outputs;
        @(posedge clk) disable iff (!rst_b)
        $past(state) == power_seq_pkg::Sleep |-> hostRailEnable && hostClockAuxOn
            && !hostClockHfOn && !transmitterEnable && !receiverEnable;
    endproperty
    a_sleep_outputs: assert property (p_sleep_outputs) else $error("sleep outputs wrong"); // R2

    property p_wake_starts;
        @(posedge clk) disable iff (!rst_b)
        (state == power_seq_pkg::PowerDown && wakeRise && !mainEn)
            |=> state == power_seq_pkg::Startup && fromWake;
    endproperty
    a_wake_starts: assert property (p_wake_starts) else $error("wake edge ignored"); // R3

    property p_wake_timeout;
        @(posedge clk) disable iff (!rst_b)
        (state == power_seq_pkg::WakeWait && wakeExpired && !mainEn)
            |=> state == power_seq_pkg::PowerDown;
    endproperty
    a_wake_timeout: assert property (p_wake_timeout) else $error("wake window not ended"); // R4

    property p_stay_active;
        @(posedge clk) disable iff (!rst_b)
        (isActive && mainEn) |=> isActive;
    endproperty
    a_stay_active: assert property (p_stay_active) // R5
        else $error("left active with enable high");

    property p_fast_after_settle;
        @(posedge clk) disable iff (!rst_b)
        $rose(hostClockHfOn) |-> $past(settled, 2);
    endproperty
    a_fast_after_settle: assert property (p_fast_after_settle) // R6
        else $error("fast clock early");

    property p_enable_to_fast;
        @(posedge clk) disable iff (!rst_b)
        s_fastClockUp |=> ##1 hostClockHfOn && !hostClockAuxOn;
    endproperty
    a_enable_to_fast: assert property (p_enable_to_fast) else $error("fast clock late"); // R14

    property p_standby_radio_off;
        @(posedge clk) disable iff (!rst_b)
        // enable still held, so the fast clock must stay up two edges on
        (isActive && standby && mainEn)
            |=> ##1 !transmitterEnable && !receiverEnable && hostClockHfOn;
    endproperty
    a_standby_radio_off: assert property (p_standby_radio_off) // R10
        else $error("standby radio on");

    property p_mode1_recover;
        @(posedge clk) disable iff (!rst_b)
        // a mode write or a dropped enable in that cycle would change the outcome
        (recoverCnt == 16'h0001 && isActive && wantTx && mainEn && !wrCsc)
            |=> ##1 transmitterEnable;
    endproperty
    a_mode1_recover: assert property (p_mode1_recover) else $error("recovery did not end"); // R11

    property p_rx_only;
        @(posedge clk) disable iff (!rst_b)
        receiverEnable && !transmitterEnable |-> $past(rxOnly) || $past(recovering);
    endproperty
    a_rx_only: assert property (p_rx_only) else $error("receive without cause"); // R12

    property p_tx_needs_rf;
        @(posedge clk) disable iff (!rst_b)
        transmitterEnable |-> receiverEnable && $past(rfOn) && !$past(standby);
    endproperty
    a_tx_needs_rf: assert property (p_tx_needs_rf) else $error("transmit without rf bit"); // R13

    property p_csc_write;
        @(posedge clk) disable iff (!rst_b)
        wrCsc |=> csc == $past(pwdata[7:0])
            ##1 supplyFiveVolt == csc[power_seq_pkg::CSC_SUPPLY5_BIT];
    endproperty
    a_csc_write: assert property (p_csc_write) else $error("control write lost"); // R15

    property p_half_power;
        @(posedge clk) disable iff (!rst_b)
        halfPower |-> $past(csc[power_seq_pkg::CSC_HALF_BIT]) && $past(wantTx);
    endproperty
    a_half_power: assert property (p_half_power) else $error("half power wrong"); // R16
endmodule // reader_power_mode_sequencer
`default_nettype wire

// File: rtl/power_seq_pkg.sv
// Purpose: constants for the reader power-mode sequencer
// Assumes: 100 MHz clk, APB register access, one aligned word per register
// Notes: cycle counts scale with CLK_MHZ; rules follow
// Contract
// R1 - main enable runs regulators, oscillator, fast clock
// R2 - sleep keeps rail and slow clock only
// R3 - wake rising edge starts supplies like enable
// R4 - no enable within window: back to power down
// R5 - wake start stays active while enable high
// R6 - fast clock only after settle and stable
// R7 - host spaces enable and wake edges apart
// R8 - host never raises both pins together
// R9 - active mode picked by status control bits
// R10 - standby bit: radio off, clock kept
// R11 - bits five and one clear: mode one
// R12 - bit one: receiver only, transmitter off
// R13 - bit five: transmitter and receiver on
// R14 - fast clock up means ready for host
// R15 - bit zero picks supply, five volt default
// R16 - bit four halves transmitter output power
package power_seq_pkg;
    // register byte addresses
    localparam logic [7:0] CSC_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    // status control field positions
    localparam int CSC_SUPPLY5_BIT = 0;
    localparam int CSC_RXONLY_BIT = 1;
    localparam int CSC_RXSWAP_BIT = 3;
    localparam int CSC_HALF_BIT = 4;
    localparam int CSC_RFON_BIT = 5;
    localparam int CSC_STANDBY_BIT = 7;
    localparam logic [7:0] CSC_RESET = 8'h01; // five volt supply after reset
    // timing
    localparam int CLK_MHZ = 100;
    localparam int WAKE_WINDOW_US = 100;
    localparam int STANDBY_RECOVER_US = 100;
    localparam int MODE1_RECOVER_US = 25;
    localparam int WAKE_WINDOW_CYCLES = WAKE_WINDOW_US * CLK_MHZ;
    localparam int STANDBY_RECOVER_CYCLES = STANDBY_RECOVER_US * CLK_MHZ;
    localparam int MODE1_RECOVER_CYCLES = MODE1_RECOVER_US * CLK_MHZ;
    localparam int CNT_W = 16;
    // sequencer states
    typedef enum logic [2:0] {
        PowerDown,
        Sleep,
        Startup,
        WakeWait,
        Active
    } seq_state_t;
endpackage

// File: verification/host_pin_model.sv
// Purpose: host side of the enable pins for the power-mode sequencer
// Assumes: bench asks for pin levels, model paces the edges
// Notes: gap is a shortened stand-in for the long host spacing
`timescale 1ns/1ps
`default_nettype none
module host_pin_model #(
    parameter int GAP = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wantMain,
    input wire logic wantWake,
    output logic mainEnablePin,
    output logic wakeEnablePin
);
    int quiet; // cycles since the last pin edge

    // one pin moves at a time, never closer than the gap
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            quiet <= GAP;
            mainEnablePin <= 1'b0;
            wakeEnablePin <= 1'b0;
        end else if (quiet < GAP) begin
            quiet <= quiet + 1;
        end else if (wantMain != mainEnablePin) begin
            mainEnablePin <= wantMain;
            quiet <= 0;
        end else if (wantWake != wakeEnablePin) begin
            wakeEnablePin <= wantWake;
            quiet <= 0;
        end
    end
endmodule // host_pin_model
`default_nettype wire

// File: verification/tb_reader_power_mode_sequencer.sv
// Purpose: self-checking bench for the power-mode sequencer
// Assumes: zero-wait apb slave, host pins paced by host_pin_model
// Notes: wake window and standby recovery shortened by parameters
`timescale 1ns/1ps
`default_nettype none
module tb_reader_power_mode_sequencer;
    localparam int WAKE = 20; // short wake window keeps the run brief
    localparam int STBY = 30; // short standby recovery
    logic clk, rst_b, wantMain, wantWake, settled, stable; // stimulus
    logic psel, penable, pwrite, pready, pslverr, err; // apb
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic mainPin, wakePin;
    logic regEn, oscEn, rail, aux, hf, tx, rx, half, five, swap; // outputs
    logic [7:0] obs; // power and radio outputs packed
    int n_mismatch = 0;
    int compares = 0;
    // mode table: control value, expected tx rx half, wait bound
    localparam int M1WAIT = power_seq_pkg::MODE1_RECOVER_CYCLES + 10; // mode one bound
    // standby follows a radio-on mode so that its switch-off is visible
    logic [7:0] modeCsc [7] = '{8'h21, 8'h81, 8'h31, 8'h0b, 8'h01, 8'h29, 8'h20};
    logic [2:0] modeRadio [7] = '{3'h6, 3'h0, 3'h7, 3'h2, 3'h0, 3'h6, 3'h6};
    int modeWait [7] = '{M1WAIT, 10, STBY + 10, 10, 10, M1WAIT, 10};
    assign obs = {regEn, oscEn, rail, aux, hf, tx, rx, half};

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    host_pin_model #(.GAP(8)) u_host (.clk(clk), .rst_b(rst_b), .wantMain(wantMain),
        .wantWake(wantWake), .mainEnablePin(mainPin), .wakeEnablePin(wakePin));

    reader_power_mode_sequencer #(.WAKE_CYCLES(WAKE), .STBY_CYCLES(STBY)) u_dut (
        .clk(clk), .rst_b(rst_b), .mainEnablePin(mainPin), .wakeEnablePin(wakePin),
        .regulatorsSettled(settled), .oscillatorStable(stable), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .regulatorEnable(regEn),
        .oscillatorEnable(oscEn), .hostRailEnable(rail), .hostClockAuxOn(aux),
        .hostClockHfOn(hf), .transmitterEnable(tx), .receiverEnable(rx),
        .halfPower(half), .supplyFiveVolt(five), .rxInputSwap(swap));

    // verdict and end of run
    task automatic report_and_stop();
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one comparison, counted
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            check(1'b0, 1'b1);
            report_and_stop();
        end
    endtask

    // bounded wait for the masked outputs, then compare
    task automatic waitObs(input logic [7:0] mask, input logic [7:0] val, input int bound);
        int n;
        n = 0;
        while ((obs & mask) !== val && n < bound) begin
            @(posedge clk);
            n++;
        end
        check(obs & mask, val);
        if ((obs & mask) !== val) report_and_stop();
    endtask

    // main sequence
    initial begin
        {rst_b, wantMain, wantWake, settled, stable} = 5'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        check(obs, 8'h00);
        check(five, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h01);
        apb(1'b0, 8'h08, 32'h0);
        check(err, 1'b1);
        // refused writes: unmapped errors, status ignores, control untouched
        apb(1'b1, 8'h08, 32'h000000a0);
        check(err, 1'b1);
        apb(1'b1, 8'h04, 32'h000000a0);
        check(err, 1'b0);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h01);
        // start by main enable; fast clock waits for both flags
        wantMain <= 1'b1;
        waitObs(8'hf8, 8'hf0, 20);
        settled <= 1'b1;
        repeat (10) @(posedge clk);
        check(obs[7:3], 5'h1e);
        stable <= 1'b1;
        waitObs(8'hff, 8'he8, 10);
        // every radio mode, with recovery from standby and mode one
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, 8'h00, {24'h0, modeCsc[i]});
            waitObs(8'hff, {5'h1d, modeRadio[i]}, modeWait[i]);
            repeat (2) @(posedge clk);
            check({swap, five}, {modeCsc[i][3], modeCsc[i][0]});
            apb(1'b0, 8'h00, 32'h0);
            check(rd, {24'h0, modeCsc[i]});
        end
        // sleep keeps rail and slow clock, wake low powers down
        wantWake <= 1'b1;
        repeat (3) @(posedge clk);
        wantMain <= 1'b0;
        waitObs(8'hff, 8'h30, 40);
        wantWake <= 1'b0;
        waitObs(8'hff, 8'h00, 40);
        // wake start without main enable falls back after the window
        {settled, stable} <= 2'b00;
        wantWake <= 1'b1;
        waitObs(8'hf8, 8'hf0, 40);
        repeat (10) @(posedge clk);
        check(obs[7:3], 5'h1e);
        {settled, stable} <= 2'b11;
        waitObs(8'hf8, 8'he8, 10);
        apb(1'b0, 8'h04, 32'h0);
        check(rd[4:0], 5'h13);
        waitObs(8'hff, 8'h00, WAKE + 10);
        // wake start confirmed by main enable stays active
        wantWake <= 1'b0;
        repeat (12) @(posedge clk);
        wantWake <= 1'b1;
        waitObs(8'hf8, 8'he8, 40);
        wantMain <= 1'b1;
        repeat (100) @(posedge clk);
        check(obs[7:3], 5'h1d);
        apb(1'b0, 8'h04, 32'h0);
        check(rd[2:0], 3'h4);
        report_and_stop();
    end
endmodule // tb_reader_power_mode_sequencer
`default_nettype wire
